// >>> design/itc_regs.svh
// register offsets, field positions and reset values of the timer channel
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH
`define ITC_OFF_CTRL      4'h0
`define ITC_OFF_COUNT     4'h4
`define ITC_OFF_STATUS    4'h8
`define ITC_CTRL_BCD      0
`define ITC_CTRL_MODE_LSB 1
`define ITC_CTRL_FMT_LSB  4
`define ITC_RST_COUNT     17'h00000
`define ITC_RST_CR        16'h0000
`define ITC_ZERO_COUNT    17'h10000
`define ITC_ONE_SQUARE    17'h10001
`endif

// >>> design/itc_pkg.sv
// types shared by the timer channel
package itc_pkg;
  typedef enum logic [2:0] {
    MODE_TC, MODE_ONESHOT, MODE_RATE, MODE_SQUARE, MODE_SWSTROBE, MODE_HWSTROBE
  } itc_mode_t;
  typedef enum logic [1:0] {FMT_LATCH, FMT_LSB, FMT_MSB, FMT_BOTH} itc_fmt_t;
endpackage

// >>> design/itc_timer.sv
// one 16-bit down-counter channel with a wishbone register port
`timescale 1ns/100ps
`include "itc_regs.svh"
module itc_timer (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // counter pins
  input  wire logic        cnt_clk_i,
  input  wire logic        gate_i,
  output logic             out_o
);
  import itc_pkg::*;

  // one count step, binary or four decades
  function automatic logic [16:0] dec1(input logic [16:0] x, input logic bcd);
    logic [16:0] r;
    logic        borrow;
    r = x;
    borrow = 1'b1;
    if (!bcd) begin
      r = x - 17'h00001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (x[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = x[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
      if (borrow) begin
        r[16] = 1'b0;
      end
    end
    return r;
  endfunction

  function automatic itc_mode_t decode_mode(input logic [2:0] m);
    itc_mode_t r;
    case (m)
      3'h0:      r = MODE_TC;
      3'h1:      r = MODE_ONESHOT;
      3'h2, 3'h6: r = MODE_RATE;
      3'h3, 3'h7: r = MODE_SQUARE;
      3'h4:      r = MODE_SWSTROBE;
      default:   r = MODE_HWSTROBE;
    endcase
    return r;
  endfunction

  // state
  itc_mode_t   mode;
  itc_fmt_t    fmt;
  logic        bcd;
  logic [15:0] cr;
  logic        wr_msb;
  logic        rd_msb;
  logic        have_cnt;
  logic [16:0] cnt;
  logic        run;
  logic        arm;
  logic        extra;
  logic        latched;
  logic [15:0] latch_val;
  logic        cclk_q;
  logic        gate_q;

  // next values
  logic [16:0] next_cnt;
  logic        next_run;
  logic        next_arm;
  logic        next_out;
  logic        next_extra;

  // bus decode
  wire logic     acc      = cyc_i & stb_i & ~ack_o & ce_i;
  wire logic     a_ctrl   = adr_i == `ITC_OFF_CTRL;
  wire logic     a_count  = adr_i == `ITC_OFF_COUNT;
  wire logic     a_stat   = adr_i == `ITC_OFF_STATUS;
  wire logic     wr_lane  = acc & we_i & sel_i[0];
  wire logic     wr_ctrl  = wr_lane & a_ctrl;
  wire logic     wr_cnt   = wr_lane & a_count;
  wire logic     rd_cnt   = acc & ~we_i & a_count;
  wire itc_fmt_t cmd_fmt  = itc_fmt_t'(dat_i[`ITC_CTRL_FMT_LSB +: 2]);
  wire logic     is_latch = wr_ctrl & (cmd_fmt == FMT_LATCH);
  wire logic     is_prog  = wr_ctrl & (cmd_fmt != FMT_LATCH);
  wire itc_mode_t new_mode = decode_mode(dat_i[`ITC_CTRL_MODE_LSB +: 3]);
  wire logic     cnt_done = wr_cnt & ((fmt != FMT_BOTH) | wr_msb);

  // count value being written
  wire logic [15:0] next_cr = (fmt == FMT_LSB) ? {8'h00, dat_i[7:0]} :
                              (fmt == FMT_MSB) ? {dat_i[7:0], 8'h00} :
                              wr_msb ? {dat_i[7:0], cr[7:0]} : {cr[15:8], dat_i[7:0]};

  // pin events
  wire logic tick      = ce_i & cnt_clk_i & ~cclk_q;
  wire logic gate_rise = ce_i & gate_i & ~gate_q;
  wire logic hold_mode = (mode == MODE_ONESHOT) | (mode == MODE_HWSTROBE);
  wire logic wave_mode = (mode == MODE_RATE) | (mode == MODE_SQUARE);
  wire logic gate_ok   = hold_mode | gate_i;

  // effective count
  wire logic [16:0] eff = (cr == 16'h0000) ? `ITC_ZERO_COUNT :
                          ((mode == MODE_SQUARE) & (cr == 16'h0001)) ? `ITC_ONE_SQUARE :
                          {1'b0, cr};
  wire logic [16:0] sq_half = {eff[16:1], 1'b0};
  wire logic [16:0] dec_1   = dec1(cnt, bcd);
  wire logic [16:0] dec_2   = dec1(dec_1, bcd);

  // arming of a load
  wire logic arm_write = cnt_done & ~hold_mode & ~(run & wave_mode);
  wire logic arm_gate  = gate_rise & have_cnt & (mode != MODE_TC);

  // readback
  wire logic [15:0] rd_src  = latched ? latch_val : cnt[15:0];
  wire logic        rd_hi   = (fmt == FMT_MSB) | ((fmt == FMT_BOTH) & rd_msb);
  wire logic [7:0]  rd_byte = rd_hi ? rd_src[15:8] : rd_src[7:0];
  wire logic        rd_last = rd_cnt & ((fmt != FMT_BOTH) | rd_msb);
  wire logic [31:0] rd_mux  = a_ctrl  ? {26'h0, fmt, mode, bcd} :
                              a_count ? {24'h0, rd_byte} :
                              a_stat  ? {29'h0, latched, run, out_o} : 32'h0;

  always_comb begin
    next_cnt   = cnt;
    next_run   = run;
    next_arm   = arm | arm_write | arm_gate;
    next_out   = out_o;
    next_extra = extra;
    if (ce_i & wave_mode & ~gate_i) begin
      next_run = 1'b0;
      next_out = 1'b1;
    end
    if (tick & arm & gate_ok) begin
      next_arm   = arm_write;
      next_run   = 1'b1;
      next_extra = 1'b0;
      next_cnt   = (mode == MODE_SQUARE) ? sq_half : eff;
      next_out   = ~((mode == MODE_ONESHOT) | (mode == MODE_TC));
    end else if (tick & run & gate_ok) begin
      case (mode)
        MODE_ONESHOT: begin
          next_cnt = dec_1;
          if (cnt == 17'h00001) begin
            next_out = 1'b1;
            next_run = 1'b0;
          end
        end
        MODE_RATE: begin
          if (cnt == 17'h00002) begin
            next_cnt = dec_1;
            next_out = 1'b0;
          end else if (cnt == 17'h00001) begin
            next_cnt = eff;
            next_out = 1'b1;
          end else begin
            next_cnt = dec_1;
          end
        end
        MODE_SQUARE: begin
          if (cnt != 17'h00002) begin
            next_cnt = dec_2;
          end else if (out_o & eff[0] & ~extra) begin
            next_extra = 1'b1;
          end else begin
            next_out   = ~out_o;
            next_cnt   = sq_half;
            next_extra = 1'b0;
          end
        end
        default: begin
          if (cnt == 17'h00001) begin
            next_cnt = dec_1;
            if (mode == MODE_TC) begin
              next_out = 1'b1;
              next_run = 1'b0;
            end else begin
              next_out = 1'b0;
            end
          end else if (cnt == 17'h00000) begin
            next_out = 1'b1;
            next_run = 1'b0;
          end else begin
            next_cnt = dec_1;
          end
        end
      endcase
    end
    if (is_prog) begin
      next_cnt   = `ITC_RST_COUNT;
      next_run   = 1'b0;
      next_arm   = 1'b0;
      next_extra = 1'b0;
      next_out   = new_mode != MODE_TC;
    end
  end

  // bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_o <= acc;
      dat_o <= (acc & ~we_i) ? rd_mux : 32'h0;
    end
  end

  // programming and byte pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode     <= MODE_TC;
      fmt      <= FMT_LSB;
      bcd      <= 1'b0;
      cr       <= `ITC_RST_CR;
      wr_msb   <= 1'b0;
      rd_msb   <= 1'b0;
      have_cnt <= 1'b0;
    end else if (is_prog) begin
      mode     <= new_mode;
      fmt      <= cmd_fmt;
      bcd      <= dat_i[`ITC_CTRL_BCD];
      wr_msb   <= 1'b0;
      rd_msb   <= 1'b0;
      have_cnt <= 1'b0;
    end else begin
      if (wr_cnt) begin
        cr     <= next_cr;
        wr_msb <= (fmt == FMT_BOTH) & ~wr_msb;
      end
      if (cnt_done) begin
        have_cnt <= 1'b1;
      end
      if (rd_cnt) begin
        rd_msb <= (fmt == FMT_BOTH) & ~rd_msb;
      end
    end
  end

  // latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched   <= 1'b0;
      latch_val <= 16'h0000;
    end else if (is_latch & ~latched) begin
      latched   <= 1'b1;
      latch_val <= cnt[15:0];
    end else if (rd_last) begin
      latched   <= 1'b0;
    end
  end

  // counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= `ITC_RST_COUNT;
      run    <= 1'b0;
      arm    <= 1'b0;
      extra  <= 1'b0;
      out_o  <= 1'b1;
      cclk_q <= 1'b0;
      gate_q <= 1'b0;
    end else if (ce_i) begin
      cnt    <= next_cnt;
      run    <= next_run;
      arm    <= next_arm;
      extra  <= next_extra;
      out_o  <= next_out;
      cclk_q <= cnt_clk_i;
      gate_q <= gate_i;
    end
  end

  prog_high_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_prog & (new_mode != MODE_TC) |=> out_o & ~run & ~arm)
    else $error("output not high and idle after programming");

  oneshot_low_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick & arm & (mode == MODE_ONESHOT) & ~is_prog |=> ~out_o & run)
    else $error("one-shot output not low after trigger");

  oneshot_keep_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick & run & ~arm & (mode == MODE_ONESHOT) & ~gate_i & (cnt > 17'h00001) & ~is_prog
    |=> run & ~out_o)
    else $error("one-shot stopped by low gate");

  oneshot_wait_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode == MODE_ONESHOT) & run & ~arm & cnt_done & ~gate_rise |=> ~arm)
    else $error("one-shot count loaded without retrigger");

  rate_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick & run & ~arm & gate_i & ~out_o & (mode == MODE_RATE) & ~is_prog |=> out_o)
    else $error("rate pulse wider than one clock");

  gate_force_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i & wave_mode & ~gate_i & ~is_prog |=> out_o & ~run)
    else $error("low gate did not force output high");

  square_even_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode == MODE_SQUARE) & run |-> ~cnt[0])
    else $error("square count not stepping by two");

  strobe_once_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick & run & ~arm & gate_i & ~out_o & (mode == MODE_SWSTROBE) & ~is_prog
    |=> out_o & ~run)
    else $error("software strobe repeated or too wide");

  latch_freeze_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    latched & ~rd_last |=> latched & $stable(latch_val))
    else $error("latched value changed before full read");

  zero_max_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick & arm & gate_i & (cr == 16'h0000) & (mode == MODE_RATE) & ~is_prog
    |=> cnt == `ITC_ZERO_COUNT)
    else $error("zero count not taken as maximum");

endmodule // itc_timer

// >>> verif/itc_host.sv
// host bus master model for the timer channel
`timescale 1ns/100ps
module itc_host (
  // system
  input  wire logic        clk_i,
  // wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [3:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  // status
  output logic             tmo_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 4'hF;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
    tmo_o = 1'b0;
  end

  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    if (n >= 50) tmo_o = 1'b1;
  endtask
endmodule // itc_host

// >>> verif/itc_timer_tb.sv
// self-checking bench for the timer channel
`timescale 1ns/100ps
module itc_timer_tb;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        tmo;
  logic        cnt_clk;
  logic        gate;
  logic        out;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] lows;
  int          err_count;
  int          compares;

  itc_host host_u (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .tmo_o(tmo));
  itc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .cnt_clk_i(cnt_clk), .gate_i(gate), .out_o(out));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h000000, d}, q);
    if (tmo !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    host_u.xfer(1'b0, a, 32'h00000000, d);
    if (tmo !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask

  // k count ticks, counting ticks after which the output is low
  task automatic run(input int k, output logic [31:0] l);
    l = 32'h00000000;
    repeat (k) begin
      cnt_clk <= 1'b1;
      repeat (2) @(posedge clk_i);
      cnt_clk <= 1'b0;
      repeat (2) @(posedge clk_i);
      if (out !== 1'b1) l++;
    end
  endtask

  initial begin
    rst_i = 1'b1;
    cnt_clk = 1'b0;
    gate = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("out after reset", 32'h1, {31'h0, out});
    wr(4'h0, 8'h10);
    chk("tc out", 32'h0, {31'h0, out});
    // one-shot, count 4
    wr(4'h0, 8'h12);
    chk("oneshot out", 32'h1, {31'h0, out});
    wr(4'h4, 8'h04);
    run(3, lows);
    chk("oneshot no start", 32'h0, lows);
    gate <= 1'b1;
    repeat (2) @(posedge clk_i);
    run(1, lows);
    gate <= 1'b0;
    run(7, q);
    chk("oneshot lows", 32'h4, lows + q);
    // rate generator, count 3
    gate <= 1'b1;
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h14);
    chk("rate out", 32'h1, {31'h0, out});
    wr(4'h4, 8'h03);
    run(1, lows);
    run(9, lows);
    chk("rate lows", 32'h3, lows);
    // square wave, count 5
    wr(4'h0, 8'h16);
    wr(4'h4, 8'h05);
    run(1, lows);
    run(10, lows);
    chk("square lows", 32'h4, lows);
    // software strobe, count 3
    wr(4'h0, 8'h18);
    wr(4'h4, 8'h03);
    run(10, lows);
    chk("strobe lows", 32'h1, lows);
    // latch while counting, then halt and read
    wr(4'h0, 8'h14);
    wr(4'h4, 8'h08);
    run(3, lows);
    wr(4'h0, 8'h00);
    run(2, lows);
    gate <= 1'b0;
    run(1, lows);
    chk("gate low out", 32'h1, {31'h0, out});
    rd(4'h4, q);
    chk("latched count", 32'h6, q);
    rd(4'h4, q);
    chk("live count", 32'h4, q);
    rd(4'h0, q);
    chk("ctrl readback", 32'h14, q);
    rd(4'hC, q);
    chk("unmapped read", 32'h0, q);
    // square wave, low gate forces high in the low half
    gate <= 1'b1;
    wr(4'h0, 8'h16);
    wr(4'h4, 8'h04);
    run(1, q);
    run(2, lows);
    chk("square even low", 32'h1, lows);
    gate <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("gate force high", 32'h1, {31'h0, out});
    rd(4'h8, q);
    chk("status halted", 32'h1, q);
    gate <= 1'b1;
    run(5, lows);
    chk("gate restart lows", 32'h2, lows);
    // rate, decimal, two bytes
    wr(4'h0, 8'h35);
    wr(4'h4, 8'h10);
    wr(4'h4, 8'h00);
    run(3, q);
    gate <= 1'b0;
    run(1, q);
    rd(4'h4, lows);
    rd(4'h4, q);
    chk("bcd lsb", 32'h08, lows);
    chk("bcd msb", 32'h00, q);
    // zero count, latch over two bytes
    wr(4'h0, 8'h35);
    wr(4'h4, 8'h00);
    wr(4'h4, 8'h00);
    gate <= 1'b1;
    run(2, q);
    wr(4'h0, 8'h00);
    run(1, q);
    rd(4'h4, lows);
    rd(4'h4, q);
    chk("latch lsb", 32'h99, lows);
    chk("latch msb", 32'h99, q);
    gate <= 1'b0;
    run(1, q);
    rd(4'h4, q);
    chk("live lsb", 32'h98, q);
    // hardware strobe, gate triggered
    wr(4'h0, 8'h1A);
    wr(4'h4, 8'h03);
    run(2, lows);
    chk("hwstrobe wait", 32'h0, lows);
    gate <= 1'b1;
    run(1, q);
    run(5, lows);
    chk("hwstrobe lows", 32'h1, lows);
    // one-shot rewrite while running, then retrigger
    gate <= 1'b0;
    wr(4'h0, 8'h12);
    wr(4'h4, 8'h06);
    gate <= 1'b1;
    run(1, q);
    run(2, lows);
    wr(4'h4, 8'h02);
    run(6, q);
    chk("oneshot rewrite lows", 32'h6, lows + q);
    gate <= 1'b0;
    repeat (2) @(posedge clk_i);
    gate <= 1'b1;
    run(1, q);
    run(3, lows);
    chk("oneshot retrigger lows", 32'h2, lows);
    // software strobe, msb only, halt and restart from full count
    wr(4'h0, 8'h28);
    wr(4'h4, 8'h01);
    run(2, q);
    gate <= 1'b0;
    run(1, q);
    gate <= 1'b1;
    run(2, q);
    gate <= 1'b0;
    run(1, q);
    rd(4'h4, q);
    chk("strobe restart", 32'h01, q);
    test_done();
  end
endmodule // itc_timer_tb
